// [dv/ptm_pulse_src.sv]
`default_nettype none

// External pulse sources: one commanded pin goes high for a set number of
// clocks while the other two stay low, so an unselected source never edges.
module ptm_pulse_src (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       pulse_req,
   input  wire logic [1:0] pulse_sel,
   input  wire logic [7:0] pulse_len,
   output logic            clock_trigger_pin,
   output logic            capture_input_pin,
   output logic            noise_filter_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] remain;
   logic [1:0] sel_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remain <= 8'h00;
         sel_q  <= 2'h0;
      end else if (pulse_req) begin
         // Narrower pulses may legally be lost, so they are never sent.
         remain <= (pulse_len < 8'h02) ? 8'h02 : pulse_len;
         sel_q  <= pulse_sel;
      end else if (remain != 8'h00) begin
         remain <= remain - 8'h01;
      end
   end

   assign clock_trigger_pin      = (remain != 8'h00) && (sel_q == 2'h0);
   assign capture_input_pin      = (remain != 8'h00) && (sel_q == 2'h1);
   assign noise_filter_input_pin = (remain != 8'h00) && (sel_q == 2'h2);

endmodule : ptm_pulse_src

`default_nettype wire

// [dv/ptm_timer_test.sv]
`default_nettype none

module ptm_timer_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk, sys_rst, reg_write, reg_read, pulse_req;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0]  pulse_sel;
   logic [7:0]  pulse_len;
   logic        clock_trigger_pin, capture_input_pin, noise_filter_input_pin;
   logic        timer_out_pin, timer_out_oe, duty_match_flag, period_match_flag, capture_valid_flag;
   int          cyc, t_pls, n_fail, checked;

   ptm_timer ptm_timer_i (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .clock_trigger_pin, .capture_input_pin, .noise_filter_input_pin, .timer_out_pin, .timer_out_oe,
      .duty_match_flag, .period_match_flag, .capture_valid_flag);
   ptm_pulse_src ptm_pulse_src_i (.sys_clk, .sys_rst, .pulse_req, .pulse_sel, .pulse_len,
      .clock_trigger_pin, .capture_input_pin, .noise_filter_input_pin);

   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge sys_clk);
      reg_write <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge sys_clk);
      reg_read <= 1'h0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic pls(input logic [1:0] s, input logic [7:0] l);
      @(posedge sys_clk);
      pulse_req <= 1'h1;
      pulse_sel <= s;
      pulse_len <= l;
      t_pls = cyc;
      @(posedge sys_clk);
      pulse_req <= 1'h0;
   endtask : pls
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chkr(input logic [15:0] g, input int lo, input int hi);
      checked++;
      if ((g >= lo && g <= hi) !== 1'h1) begin
         n_fail++;
         $display("ERROR %0t: got %h outside %0d..%0d", $time, g, lo, hi);
      end
   endtask : chkr
   task automatic chkf(input logic f, input logic e);
      chk({15'h0000, f}, {15'h0000, e});
   endtask : chkf
   // Counting active cycles over whole periods is immune to output latency.
   task automatic hic(input int n, output logic [15:0] c);
      c = 16'h0000;
      repeat (n) begin
         @(posedge sys_clk);
         #1 if (timer_out_pin === 1'h1) c++;
      end
   endtask : hic
   // Clear select is always set: it must be ignored in every mode tested.
   function automatic logic [15:0] ctl(logic on, logic [1:0] md, logic [1:0] io, logic oc, logic pol,
                                      logic [1:0] src, logic [1:0] tc);
      return {4'h0, tc, src == 2'h2, src == 2'h0, pol, oc, 1'h1, io, md, on};
   endfunction : ctl

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [15:0] v;
      for (int a = 0; a < 8; a++) begin
         rd(4'(a), v);
         chk(v, ptm_pkg::WORD_ZERO);
      end
      chk({11'h000, timer_out_pin, timer_out_oe, duty_match_flag, period_match_flag, capture_valid_flag}, 16'h0000);
      wr(ptm_pkg::ADDR_PERIOD, 16'h0155);
      wr(4'h7, 16'hFFFF);
      wr(ptm_pkg::ADDR_COUNT, 16'h0123);
      rd(ptm_pkg::ADDR_PERIOD, v);
      chk(v, 16'h0155);
      rd(4'h7, v);
      chk(v, 16'h0000);
      rd(ptm_pkg::ADDR_COUNT, v);
      chk(v, 16'h0000);
   endtask : t_reset

   task automatic t_pwm;
      logic [15:0] c;
      wr(ptm_pkg::ADDR_PERIOD, 16'h000A);
      wr(ptm_pkg::ADDR_DUTY, 16'h0003);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PWM, 1'h1, 1'h0, 2'h1, 2'h0));
      idle(20);
      chkf(timer_out_oe, 1'h1);
      hic(100, c);
      chk(c, 16'h001E);
      wr(ptm_pkg::ADDR_DUTY, 16'h000C);
      idle(20);
      hic(100, c);
      chk(c, 16'h0064);
      wr(ptm_pkg::ADDR_DUTY, 16'h0003);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PWM, 1'h1, 1'h1, 2'h1, 2'h0));
      idle(20);
      hic(100, c);
      chk(c, 16'h0046);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_FORCE_LO, 1'h1, 1'h0, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_STATUS, 16'h0007);
      hic(100, c);
      chk(c, 16'h0000);
      chkf(duty_match_flag, 1'h1);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_FORCE_HI, 1'h1, 1'h0, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_PERIOD, 16'h0000);
      wr(ptm_pkg::ADDR_DUTY, 16'h0200);
      hic(100, c);
      chk(c, 16'h0064);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PWM, 1'h1, 1'h0, 2'h1, 2'h0));
      idle(1030);
      hic(2048, c);
      chk(c, 16'h0400);
   endtask : t_pwm

   task automatic t_pulse;
      logic [15:0] c, a, b;
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h0, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PULSE, 1'h1, 1'h0, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_PERIOD, 16'h0005);
      wr(ptm_pkg::ADDR_DUTY, 16'h0014);
      wr(ptm_pkg::ADDR_STATUS, 16'h0007);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PULSE, 1'h1, 1'h0, 2'h1, 2'h0));
      hic(60, c);
      // The pulse spans the restart cycle and then counts zero through duty.
      chkr(c, 22, 22);
      chkf(duty_match_flag, 1'h1);
      rd(ptm_pkg::ADDR_COUNT, a);
      idle(5);
      rd(ptm_pkg::ADDR_COUNT, b);
      chk(b, a);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h0, ptm_pkg::PTM_MODE_PWM, ptm_pkg::IO_PULSE, 1'h1, 1'h0, 2'h1, 2'h0));
      pls(2'h0, 8'h03);
      hic(60, c);
      chkr(c, 22, 22);
   endtask : t_pulse

   task automatic t_capture;
      logic [15:0] a, b, c;
      int t1;
      wr(ptm_pkg::ADDR_PERIOD, 16'h0000);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h0, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_RISE, 1'h1, 1'h1, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_STATUS, 16'h0007);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_RISE, 1'h1, 1'h1, 2'h1, 2'h0));
      chkf(timer_out_oe, 1'h0);
      rd(ptm_pkg::ADDR_COUNT, a);
      idle(8);
      rd(ptm_pkg::ADDR_COUNT, b);
      chk(b - a, 16'h000A);
      pls(2'h1, 8'h03);
      t1 = t_pls;
      idle(10);
      chkf(duty_match_flag, 1'h1);
      rd(ptm_pkg::ADDR_DUTY, a);
      pls(2'h1, 8'h03);
      idle(10);
      rd(ptm_pkg::ADDR_DUTY, b);
      chk(b - a, 16'(t_pls - t1));
      idle(50);
      chkf(duty_match_flag, 1'h1);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_NONE, 1'h0, 1'h0, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_STATUS, 16'h0007);
      pls(2'h1, 8'h03);
      idle(10);
      chkf(duty_match_flag, 1'h0);
      rd(ptm_pkg::ADDR_DUTY, c);
      chk(c, b);
      for (int s = 0; s < 3; s++) begin
         wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_RISE, 1'h0, 1'h0, 2'(s), 2'h0));
         wr(ptm_pkg::ADDR_STATUS, 16'h0007);
         pls(2'((s + 1) % 3), 8'h03);
         idle(10);
         chkf(duty_match_flag, 1'h0);
         pls(2'(s), 8'h03);
         idle(10);
         chkf(duty_match_flag, 1'h1);
      end
      wr(ptm_pkg::ADDR_PERIOD, 16'h0028);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h0, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_RISE, 1'h0, 1'h0, 2'h1, 2'h0));
      wr(ptm_pkg::ADDR_STATUS, 16'h0007);
      wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_RISE, 1'h0, 1'h0, 2'h1, 2'h0));
      idle(50);
      chkf(period_match_flag, 1'h1);
      rd(ptm_pkg::ADDR_COUNT, c);
      chkr(c, 0, 39);
      wr(ptm_pkg::ADDR_PERIOD, 16'h0000);
      for (int tc = 1; tc < 4; tc++) begin
         wr(ptm_pkg::ADDR_CTRL, ctl(1'h0, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_BOTH, 1'h0, 1'h0, 2'h1, 2'(tc)));
         wr(ptm_pkg::ADDR_CTRL, ctl(1'h1, ptm_pkg::PTM_MODE_CAPTURE, ptm_pkg::EDGE_BOTH, 1'h0, 1'h0, 2'h1, 2'(tc)));
         pls(2'h1, 8'h1E);
         idle(45);
         rd(ptm_pkg::ADDR_COUNT, c);
         if (tc == 1) chkr(c, 35, 50);
         else chkr(c, 5, 20);
         chkf(capture_valid_flag, tc != 1);
         rd(ptm_pkg::ADDR_SECCAP, c);
         if (tc == 1) chkr(c, 29, 31);
      end
   endtask : t_capture

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      {reg_write, reg_read, pulse_req, reg_addr, reg_wdata, pulse_sel, pulse_len} = '0;
      sys_rst = 1'h1;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'h0;
      t_reset();
      t_pwm();
      t_pulse();
      t_capture();
      print_verdict();
   end

   // The scenarios need about 4300 clocks; this allows ample margin.
   initial begin
      #400000;
      n_fail++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict();
   end

endmodule : ptm_timer_test

`default_nettype wire

// [hw/ptm_edge_sync.sv]
`default_nettype none

// Two-stage synchroniser with edge detection; a pulse shorter than the
// sampling window may vanish, which the capture logic tolerates.
module ptm_edge_sync (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic pin_async,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else begin
         meta   <= pin_async;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign level = stable;
   assign rise  = stable & ~prev;
   assign fall  = ~stable & prev;

endmodule : ptm_edge_sync

`default_nettype wire

// [hw/ptm_timer.sv]
`default_nettype none

module ptm_timer (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [15:0] reg_rdata,
   input  wire logic        clock_trigger_pin,
   input  wire logic        capture_input_pin,
   input  wire logic        noise_filter_input_pin,
   output logic             timer_out_pin,
   output logic             timer_out_oe,
   output logic             duty_match_flag,
   output logic             period_match_flag,
   output logic             capture_valid_flag
);

   ////////////////////////////////////////////////////////////////////////////

   logic [15:0] ctrl_word;
   logic        counter_on;
   logic        on_prev;
   logic [9:0]  count;
   logic [9:0]  duty_compare_value;
   logic [9:0]  period_compare_value;
   logic [9:0]  secondary_capture_value;
   logic        cap_pend;
   logic        cap_pend_primary;

   logic [9:0]  next_count;
   logic        next_on;
   logic        next_pin;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: 0 capture input, 1 clock trigger, 2 noise filter.

   wire  [2:0] pin_async;
   logic [2:0] pin_level;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   assign pin_async = {noise_filter_input_pin, clock_trigger_pin, capture_input_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         ptm_edge_sync u_sync (
            .sys_clk   (sys_clk),
            .sys_rst   (sys_rst),
            .pin_async (pin_async[gi]),
            .level     (pin_level[gi]),
            .rise      (pin_rise[gi]),
            .fall      (pin_fall[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control decoding.

   function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         ptm_pkg::EDGE_RISE: edge_match = r;
         ptm_pkg::EDGE_FALL: edge_match = f;
         ptm_pkg::EDGE_BOTH: edge_match = r | f;
         default:            edge_match = 1'b0;
      endcase
   endfunction : edge_match

   wire ptm_pkg::ptm_mode_t mode_sel = ptm_pkg::ptm_mode_t'(ctrl_word[ptm_pkg::MODE_LSB +: 2]);
   wire [1:0] io_ctrl               = ctrl_word[ptm_pkg::IO_LSB +: 2];
   wire [1:0] clear_condition       = ctrl_word[ptm_pkg::TCLR_LSB +: 2];
   wire       output_initial_level  = ctrl_word[ptm_pkg::OC_BIT];
   wire       output_polarity       = ctrl_word[ptm_pkg::POL_BIT];
   wire       capture_source_select = ctrl_word[ptm_pkg::CAPTS_BIT];
   wire       filter_select         = ctrl_word[ptm_pkg::NFSEL_BIT];

   wire wr_ctrl   = reg_write && (reg_addr == ptm_pkg::ADDR_CTRL);
   wire wr_duty   = reg_write && (reg_addr == ptm_pkg::ADDR_DUTY);
   wire wr_period = reg_write && (reg_addr == ptm_pkg::ADDR_PERIOD);
   wire wr_status = reg_write && (reg_addr == ptm_pkg::ADDR_STATUS);

   // Pulse mode is PWM mode with the output field at 11; software keeps it there.
   wire is_pulse = (mode_sel == ptm_pkg::PTM_MODE_PWM) && (io_ctrl == ptm_pkg::IO_PULSE);
   wire is_pwm   = (mode_sel == ptm_pkg::PTM_MODE_PWM) && !is_pulse;
   wire is_cap   = (mode_sel == ptm_pkg::PTM_MODE_CAPTURE);

   wire on_rise = counter_on && !on_prev;
   wire running = counter_on && !on_rise;

   // A zero period value wraps the counter through its full 1024 states.
   wire [9:0]  period_last = (period_compare_value == ptm_pkg::CNT_ZERO) ?
                             ptm_pkg::CNT_MAX : (period_compare_value - ptm_pkg::CNT_ONE);
   wire [10:0] period_eff  = (period_compare_value == ptm_pkg::CNT_ZERO) ?
                             ptm_pkg::PERIOD_FULL : {1'b0, period_compare_value};
   wire period_hit = running && !is_pulse && (count == period_last);
   wire duty_hit   = running && (count == duty_compare_value);

   ////////////////////////////////////////////////////////////////////////////
   // Capture path.

   // The filter output takes priority over the pin choice when selected.
   wire [1:0] src_idx = filter_select ? 2'h2 : (capture_source_select ? 2'h1 : 2'h0);
   wire cap_rise  = pin_rise[src_idx];
   wire cap_fall  = pin_fall[src_idx];
   wire cap_edge  = is_cap && running && edge_match(io_ctrl, cap_rise, cap_fall);
   wire cap_clr   = is_cap && running && (clear_condition != ptm_pkg::TCLR_PERIOD) &&
                    edge_match(clear_condition - 2'h1, cap_rise, cap_fall);
   // A capture on the edge that also clears the counter lands in the primary
   // register, so the primary holds the full interval between clearing edges.
   wire cap_primary = (clear_condition == ptm_pkg::TCLR_PERIOD) || cap_clr;

   wire trig_rise = is_pulse && pin_rise[1];

   ////////////////////////////////////////////////////////////////////////////
   // Counter and counter-on.

   always_comb begin
      next_count = count;
      if (on_rise) begin
         next_count = ptm_pkg::CNT_ZERO;
      end else if (counter_on) begin
         if (is_pulse) begin
            next_count = duty_hit ? count : count + ptm_pkg::CNT_ONE;
         end else if (period_hit || cap_clr) begin
            next_count = ptm_pkg::CNT_ZERO;
         end else begin
            next_count = count + ptm_pkg::CNT_ONE;
         end
      end
   end

   always_comb begin
      next_on = counter_on;
      if (wr_ctrl) begin
         next_on = reg_wdata[ptm_pkg::ON_BIT];
      end
      if (is_pulse && duty_hit) begin
         next_on = 1'b0;
      end
      if (trig_rise) begin
         next_on = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pin.

   wire pwm_active = running && ((count < duty_compare_value) ||
                     ({1'b0, duty_compare_value} >= period_eff));
   wire pwm_raw    = (io_ctrl == ptm_pkg::IO_FORCE_LO) ? 1'b0 :
                     (io_ctrl == ptm_pkg::IO_FORCE_HI) ? 1'b1 : pwm_active;
   wire wave       = is_pulse ? counter_on : pwm_raw;

   always_comb begin
      if (mode_sel == ptm_pkg::PTM_MODE_PWM) begin
         next_pin = ~(wave ^ output_initial_level) ^ output_polarity;
      end else begin
         next_pin = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_word  <= ptm_pkg::WORD_ZERO;
         counter_on <= 1'b0;
         on_prev    <= 1'b0;
         count      <= ptm_pkg::CNT_ZERO;
      end else begin
         if (wr_ctrl) begin
            ctrl_word <= reg_wdata & ptm_pkg::CTRL_WR_MASK;
         end
         counter_on <= next_on;
         on_prev    <= counter_on;
         count      <= next_count;
      end
   end

   // A capture into the primary register wins over a software write.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         duty_compare_value      <= ptm_pkg::CNT_ZERO;
         period_compare_value    <= ptm_pkg::CNT_ZERO;
         secondary_capture_value <= ptm_pkg::CNT_ZERO;
      end else begin
         if (cap_edge && cap_primary) begin
            duty_compare_value <= count;
         end else if (wr_duty) begin
            duty_compare_value <= reg_wdata[ptm_pkg::CNT_W-1:0];
         end
         if (wr_period) begin
            period_compare_value <= reg_wdata[ptm_pkg::CNT_W-1:0];
         end
         if (cap_edge && !cap_primary) begin
            secondary_capture_value <= count;
         end
      end
   end

   // Flags are write-one-to-clear; a set in the clearing cycle survives.
   wire clr_duty   = wr_status && reg_wdata[ptm_pkg::DUTY_FLAG_BIT];
   wire clr_period = wr_status && reg_wdata[ptm_pkg::PERIOD_FLAG_BIT];
   wire clr_valid  = wr_status && reg_wdata[ptm_pkg::VALID_FLAG_BIT];
   wire set_duty   = cap_pend || (!is_cap && duty_hit);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_pend           <= 1'b0;
         cap_pend_primary   <= 1'b0;
         duty_match_flag    <= 1'b0;
         period_match_flag  <= 1'b0;
         capture_valid_flag <= 1'b0;
      end else begin
         cap_pend           <= cap_edge;
         cap_pend_primary   <= cap_primary;
         duty_match_flag    <= (duty_match_flag && !clr_duty) || set_duty;
         period_match_flag  <= (period_match_flag && !clr_period) || period_hit;
         if (cap_pend) begin
            capture_valid_flag <= cap_pend_primary;
         end else if (clr_valid) begin
            capture_valid_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_out_pin <= 1'b0;
         timer_out_oe  <= 1'b0;
      end else begin
         timer_out_pin <= next_pin;
         timer_out_oe  <= (mode_sel == ptm_pkg::PTM_MODE_PWM);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read-back, valid only in the cycle after the read strobe.

   wire [15:0] status_word = {13'h0000, capture_valid_flag, period_match_flag, duty_match_flag};
   wire [15:0] read_mux =
      (reg_addr == ptm_pkg::ADDR_CTRL)   ? (ctrl_word | {15'h0000, counter_on}) :
      (reg_addr == ptm_pkg::ADDR_DUTY)   ? ptm_pkg::ptm_zext(duty_compare_value) :
      (reg_addr == ptm_pkg::ADDR_PERIOD) ? ptm_pkg::ptm_zext(period_compare_value) :
      (reg_addr == ptm_pkg::ADDR_SECCAP) ? ptm_pkg::ptm_zext(secondary_capture_value) :
      (reg_addr == ptm_pkg::ADDR_STATUS) ? status_word :
      (reg_addr == ptm_pkg::ADDR_COUNT)  ? ptm_pkg::ptm_zext(count) : ptm_pkg::WORD_ZERO;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= ptm_pkg::WORD_ZERO;
      end else begin
         reg_rdata <= reg_read ? read_mux : ptm_pkg::WORD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_pulse_start;
      is_pulse && on_rise && !trig_rise;
   endsequence

   sequence s_pulse_level;
      timer_out_pin == ~(1'b1 ^ output_initial_level) ^ output_polarity;
   endsequence

   a_pwm_period_wrap: assert property (
      is_pwm && running && (count == period_last) && !wr_ctrl |=> count == ptm_pkg::CNT_ZERO)
      else $error("PWM counter did not wrap at period end");

   a_pwm_full_duty: assert property (
      is_pwm && running && (io_ctrl == ptm_pkg::IO_PWM) &&
      ({1'b0, duty_compare_value} >= period_eff) && $stable(ctrl_word) |=>
      timer_out_pin == (output_initial_level ^ output_polarity))
      else $error("Full duty did not hold output active");

   a_clear_select_ignored: assert property (
      is_pwm && running && ctrl_word[ptm_pkg::CCLR_BIT] && duty_hit &&
      (count != period_last) && !wr_ctrl |=> count == $past(count) + ptm_pkg::CNT_ONE)
      else $error("PWM counter cleared on duty match");

   a_forced_keeps_count: assert property (
      is_pwm && running && (io_ctrl != ptm_pkg::IO_PWM) && (count != period_last) && !wr_ctrl |=>
      (count == $past(count) + ptm_pkg::CNT_ONE) ##1 timer_out_pin == $past(next_pin))
      else $error("Forced output stopped the PWM counter");

   a_pulse_start: assert property (
      s_pulse_start ##1 (count == ptm_pkg::CNT_ZERO) |-> s_pulse_level or !is_pulse)
      else $error("Pulse leading edge missing after counter-on rise");

   a_trigger_sets_on: assert property (
      trig_rise |=> counter_on)
      else $error("Trigger edge did not set counter-on");

   a_pulse_end: assert property (
      is_pulse && duty_hit && !trig_rise |=> !counter_on ##1 !wave || !is_pulse)
      else $error("Duty match did not end the pulse");

   a_pulse_no_period: assert property (
      is_pulse && running && !duty_hit && !wr_ctrl && !trig_rise |=>
      count == $past(count) + ptm_pkg::CNT_ONE && !period_hit)
      else $error("Pulse counter disturbed outside restart");

   a_capture_latch: assert property (
      cap_edge && cap_primary |=> duty_compare_value == $past(count) ##1 duty_match_flag)
      else $error("Capture did not latch and flag in time");

   a_capture_period: assert property (
      is_cap && period_hit && !wr_ctrl |=> count == ptm_pkg::CNT_ZERO && period_match_flag)
      else $error("Capture period match did not clear and flag");

   a_no_capture_none: assert property (
      is_cap && (io_ctrl == ptm_pkg::EDGE_NONE) && !wr_duty && !wr_ctrl |=>
      $stable(duty_compare_value) && $stable(secondary_capture_value))
      else $error("Capture occurred with edges disabled");

   a_no_output_capture: assert property (
      is_cap && $past(is_cap) |-> !timer_out_oe && !timer_out_pin)
      else $error("Output driven in capture mode");

   a_flag_sticky: assert property (
      duty_match_flag && !clr_duty |=> duty_match_flag)
      else $error("Duty flag dropped without a clear");

endmodule : ptm_timer

`default_nettype wire

// [inc/ptm_pkg.sv]
// How it works
// - Period value sets PWM period; zero gives 1024.
// - Duty at or above period holds output active.
// - PWM clears on period match; clear select ignored.
// - PWM counting continues when pin is forced.
// - Counter-on rise starts counter and pulse edge.
// - Trigger pin edge sets counter-on in pulse mode.
// - Duty match or software clear ends pulse.
// - Pulse duty match raises duty match flag.
// - Pulse counter resets only on counter-on rise.
// - Capture source: input pin, trigger pin, filter.
// - Capture counter free-runs while counter-on is high.
// - Active edge latches primary or secondary, flags.
// - Capture period match clears counter, flags period.
// - Edge select both high disables capture entirely.
// - Clear condition 00: period clear, primary only.
// - Clear condition 01: rising capture edge clears too.
// - Capture pulses under two clocks may be lost.
// - Latch quickly; flags follow latch one clock later.
// - Capture mode has no output function.
// - Clear condition 10: falling capture edge clears too.
// - Clear condition 11: either capture edge clears too.
// - Initial level sets polarity; polarity bit inverts.
`default_nettype none

package ptm_pkg;

   localparam int CNT_W  = 10;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_DUTY   = 4'h1;
   localparam logic [3:0] ADDR_PERIOD = 4'h2;
   localparam logic [3:0] ADDR_SECCAP = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COUNT  = 4'h5;

   localparam int ON_BIT    = 0;
   localparam int MODE_LSB  = 1;
   localparam int IO_LSB    = 3;
   localparam int CCLR_BIT  = 5;
   localparam int OC_BIT    = 6;
   localparam int POL_BIT   = 7;
   localparam int CAPTS_BIT = 8;
   localparam int NFSEL_BIT = 9;
   localparam int TCLR_LSB  = 10;

   localparam int DUTY_FLAG_BIT   = 0;
   localparam int PERIOD_FLAG_BIT = 1;
   localparam int VALID_FLAG_BIT  = 2;

   localparam logic [15:0] CTRL_WR_MASK = 16'h0FFE;
   localparam logic [15:0] WORD_ZERO    = 16'h0000;
   localparam logic [9:0]  CNT_ZERO     = 10'h000;
   localparam logic [9:0]  CNT_ONE      = 10'h001;
   localparam logic [9:0]  CNT_MAX      = 10'h3FF;
   localparam logic [10:0] PERIOD_FULL  = 11'h400;

   typedef enum logic [1:0] {
      PTM_MODE_COMPARE = 2'b00,
      PTM_MODE_CAPTURE = 2'b01,
      PTM_MODE_PWM     = 2'b10,
      PTM_MODE_TIMER   = 2'b11
   } ptm_mode_t;

   // Output control codes in PWM mode; the same field selects edges in capture mode.
   localparam logic [1:0] IO_FORCE_LO = 2'h0;
   localparam logic [1:0] IO_FORCE_HI = 2'h1;
   localparam logic [1:0] IO_PWM      = 2'h2;
   localparam logic [1:0] IO_PULSE    = 2'h3;
   localparam logic [1:0] EDGE_RISE   = 2'h0;
   localparam logic [1:0] EDGE_FALL   = 2'h1;
   localparam logic [1:0] EDGE_BOTH   = 2'h2;
   localparam logic [1:0] EDGE_NONE   = 2'h3;
   localparam logic [1:0] TCLR_PERIOD = 2'h0;

   localparam int SYS_CLK_NS        = 10;
   localparam int MIN_PULSE_NS      = 20;
   localparam int MIN_PULSE_CYC     = (MIN_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int FLAG_LAG_NS       = 5;
   localparam int FLAG_LAG_CYC      = (FLAG_LAG_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   function automatic logic [15:0] ptm_zext(input logic [9:0] v);
      ptm_zext = {6'h00, v};
   endfunction : ptm_zext

endpackage : ptm_pkg

`default_nettype wire
